// >>> alwt_pkg.sv
// Constants, register map and state types of the alarm latch and wake timer
package alwt_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_PIN_RESULT  = 10'h02a;
   localparam logic [9:0] IDX_LATCHED     = 10'h062;
   localparam logic [9:0] IDX_INSTANT     = 10'h064;
   localparam logic [9:0] IDX_MASK        = 10'h066;
   localparam logic [9:0] IDX_REG_CONTROL = 10'h069;
   localparam logic [9:0] IDX_TIMER_STAT  = 10'h070;
   localparam logic [9:0] IDX_TIMER_CMD   = 10'h094;
   // Event bit positions
   localparam int BIT_TIMER   = 12;
   localparam int BIT_POWERUP = 15;
   // Regulator control fields
   localparam int CTL_REG_EN   = 0;
   localparam int CTL_PULLUP   = 1;
   localparam int CTL_TMODE    = 2;
   localparam int CTL_OSC_KEEP = 3;
   localparam logic [3:0] CTL_RESET = 4'h5;
   localparam logic [15:0] MASK_DEFAULT = 16'h0000;
   // Timer command fields
   localparam int TMR_LSB = 0;
   localparam int TMR_MSB = 7;
   localparam int SD_BIT  = 8;
   localparam int DLY_LSB = 9;
   localparam int DLY_MSB = 10;
   localparam int AWK_BIT = 11;
   localparam logic [7:0] STEP_FINE_MAX = 8'h10;
   localparam logic [9:0] COARSE_OFFSET = 10'h00c;
   localparam logic [4:0] DLY_Q0 = 5'h00;
   localparam logic [4:0] DLY_Q1 = 5'h01;
   localparam logic [4:0] DLY_Q2 = 5'h04;
   localparam logic [4:0] DLY_Q3 = 5'h10;
   // Timing
   localparam int CLK_MHZ   = 125;
   localparam int TICK_US   = 250000;
   localparam int TICK_CYC  = TICK_US * CLK_MHZ;
   // Power modes
   localparam logic [1:0] MODE_DEEP = 2'h2;
   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ALWT_IDLE = 2'b01,
      ALWT_RUN  = 2'b10
   } alwt_tfsm_t;

   typedef struct packed {
      alwt_tfsm_t  fsm;
      logic [15:0] latched;
      logic [15:0] mask;
      logic [3:0]  ctl;
      logic        sd;
      logic        awk;
      logic        reg_off;
      logic        dly_pend;
      logic [9:0]  quarters;
      logic [4:0]  dly_q;
      logic [24:0] tick;
      logic        pulse;
      logic        aw_got;
      logic        w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [1:0]  alert_sync;
   } alwt_state_t;
endpackage : alwt_pkg

// >>> alwt_top.sv
// Alarm latch, open-drain alert, wake timer and regulator hold-off behind AXI4-Lite
// Function
// RULE1: Reading the instant register returns every event source level, unlatched.
// RULE2: An unmasked asserted source sets and holds its latched bit.
// RULE3: Alert pin is pulled low while any latched bit is set.
// RULE4: Host writes ones to latched register; exactly those flags clear.
// RULE5: Mask starts from a stored default and is host writable per bit.
// RULE6: Momentary sources stay latched until cleared by the host.
// RULE7: Power-up source follows the power-up status flag.
// RULE8: Mode bit one selects thermistor mode, zero general ADC input.
// RULE9: Pull-up on only during measurement unless continuous pull-up is set.
// RULE10: Wake timer runs in normal, sleep and deep-sleep modes.
// RULE11: Setting 1-16 is 250 ms steps, 17-255 one second steps, 0 off.
// RULE12: Every non-zero setting write starts the timer.
// RULE13: Expiry pulses the timer source; latched only when unmasked.
// RULE14: Shutdown bit turns regulator off after delay; expiry restores it.
// RULE15: Delay field gives none, 250 ms, 1 s or 4 s.
// RULE16: Alarm-wake with shutdown restores regulator on any latched alarm.
// RULE17: Host writes zeros to the top four command bits.
// RULE18: Zero setting while running aborts without pulse; regulator restored.
// RULE19: While running with shutdown set regulator stays off.
// RULE20: Timer active in deep sleep keeps the oscillator running.
// RULE21: Timer command accepted at locked and unlocked access levels.
// RULE22: Alert pin is open-drain, only ever driven low.
// RULE23: Zero bits leave flags alone; a still-asserted source re-latches.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module alwt_top #(
   parameter int TICK_CYCLES = alwt_pkg::TICK_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [15:0] event_src,
   input  wire logic        powerup_flag,
   input  wire logic [15:0] pin_voltage,
   input  wire logic        pin_measuring,
   input  wire logic [1:0]  power_mode,
   input  wire logic        alert_i,
   output      logic        alert_o,
   output      logic        alert_oe,
   output      logic        regulator_output_en,
   output      logic        pullup_en,
   output      logic        thermistor_mode,
   output      logic        general_adc_input,
   output      logic        osc_run
);

   ////////////////////////////////////////////////////////////////////////////
   // State and derived signals
   alwt_pkg::alwt_state_t q;
   alwt_pkg::alwt_state_t d;
   logic [15:0]           raw;
   logic                  wr_fire;
   logic [9:0]            wr_idx;
   logic [9:0]            rd_idx;
   logic [31:0]           wmask;
   logic [31:0]           wval;
   logic                  tmr_wr;
   logic                  running;
   logic                  tick_end;

   localparam logic [24:0] TICK_LAST = 25'(TICK_CYCLES - 1);

   // Interval in quarter seconds
   function automatic logic [9:0] alwt_quarters(input logic [7:0] s);
      logic [9:0] wide;
      wide = {2'h0, s};
      if (s <= alwt_pkg::STEP_FINE_MAX) begin
         return wide;                                                      // RULE11
      end
      return 10'((wide - alwt_pkg::COARSE_OFFSET) << 2);                   // RULE11
   endfunction : alwt_quarters

   function automatic logic [4:0] alwt_delay(input logic [1:0] f);
      unique case (f)
         2'h0: return alwt_pkg::DLY_Q0;                                    // RULE15
         2'h1: return alwt_pkg::DLY_Q1;
         2'h2: return alwt_pkg::DLY_Q2;
         default: return alwt_pkg::DLY_Q3;
      endcase
   endfunction : alwt_delay

   always_comb begin
      raw = event_src;                                                     // RULE1
      raw[alwt_pkg::BIT_TIMER] = q.pulse;                                  // RULE13
      raw[alwt_pkg::BIT_POWERUP] = powerup_flag;                           // RULE7
   end

   assign wr_fire  = q.aw_got & q.w_got & ~q.bvalid;
   assign wr_idx   = q.awaddr[11:2];
   assign rd_idx   = s_axi_araddr[11:2];
   assign wmask    = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
   assign wval     = q.wdata & wmask;
   // No access level check: the command is open at both levels
   assign tmr_wr   = wr_fire & (wr_idx == alwt_pkg::IDX_TIMER_CMD);      // RULE21
   assign running  = (q.fsm == alwt_pkg::ALWT_RUN);
   assign tick_end = (q.tick == TICK_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d = q;
      d.pulse = 1'b0;
      d.alert_sync = {q.alert_sync[0], alert_i};

      // Bus write channels, either order
      if (s_axi_awvalid & s_axi_awready) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid & s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // Latch: set wins over clear
      d.latched = (q.latched & ~(wr_fire && wr_idx == alwt_pkg::IDX_LATCHED ? wval[15:0] : 16'h0000))
                | (raw & q.mask);                                          // RULE2 RULE4 RULE6 RULE23

      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = alwt_pkg::RESP_OKAY;
         unique case (wr_idx)
            alwt_pkg::IDX_MASK: begin
               d.mask = (q.mask & ~wmask[15:0]) | wval[15:0];            // RULE5
            end
            alwt_pkg::IDX_REG_CONTROL: begin
               d.ctl = (q.ctl & ~wmask[3:0]) | wval[3:0];
            end
            alwt_pkg::IDX_LATCHED, alwt_pkg::IDX_TIMER_CMD: begin
            end
            default: begin
               d.bresp = alwt_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Wake timer, free of the power mode
      if (running) begin                                                   // RULE10
         d.tick = tick_end ? 25'h0000000 : 25'(q.tick + 25'h0000001);
         if (tick_end) begin
            if (q.dly_pend) begin
               if (q.dly_q == alwt_pkg::DLY_Q1) begin
                  d.dly_pend = 1'b0;
                  d.reg_off  = 1'b1;                                       // RULE14
               end
               d.dly_q = 5'(q.dly_q - 5'h01);
            end
            if (q.quarters == 10'h001) begin
               d.fsm      = alwt_pkg::ALWT_IDLE;
               d.pulse    = 1'b1;                                          // RULE13
               d.reg_off  = 1'b0;                                          // RULE14
               d.dly_pend = 1'b0;
            end else begin
               d.quarters = 10'(q.quarters - 10'h001);
            end
         end
         // Any latched alarm brings the regulator back early
         if (q.awk & q.sd & (q.latched != 16'h0000)) begin
            d.reg_off  = 1'b0;                                             // RULE16
            d.dly_pend = 1'b0;
         end
      end

      // Upper command bits are left to the host and ignored here
      if (tmr_wr) begin                                                    // RULE17
         if (wval[alwt_pkg::TMR_MSB:alwt_pkg::TMR_LSB] != 8'h00) begin
            d.fsm      = alwt_pkg::ALWT_RUN;                               // RULE12
            d.tick     = 25'h0000000;
            d.quarters = alwt_quarters(wval[alwt_pkg::TMR_MSB:alwt_pkg::TMR_LSB]);
            d.sd       = wval[alwt_pkg::SD_BIT];
            d.awk      = wval[alwt_pkg::AWK_BIT];
            d.dly_q    = alwt_delay(wval[alwt_pkg::DLY_MSB:alwt_pkg::DLY_LSB]);
            // Delay only matters when the regulator was on at start
            d.dly_pend = wval[alwt_pkg::SD_BIT] & q.ctl[alwt_pkg::CTL_REG_EN]
                       & (d.dly_q != alwt_pkg::DLY_Q0);                    // RULE15
            d.reg_off  = wval[alwt_pkg::SD_BIT] & ~d.dly_pend;             // RULE14
         end else if (running) begin
            d.fsm      = alwt_pkg::ALWT_IDLE;                              // RULE18
            d.reg_off  = 1'b0;
            d.dly_pend = 1'b0;
            d.pulse    = 1'b0;
         end
      end

      // Bus read
      if (q.rvalid & s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rresp  = alwt_pkg::RESP_OKAY;
         d.rdata  = 32'h00000000;
         unique case (rd_idx)
            alwt_pkg::IDX_PIN_RESULT:  d.rdata[15:0] = pin_voltage;
            alwt_pkg::IDX_LATCHED:     d.rdata[15:0] = q.latched;
            alwt_pkg::IDX_INSTANT:     d.rdata[15:0] = raw;                // RULE1
            alwt_pkg::IDX_MASK:        d.rdata[15:0] = q.mask;
            alwt_pkg::IDX_REG_CONTROL: d.rdata[3:0]  = q.ctl;
            alwt_pkg::IDX_TIMER_STAT:  d.rdata[12:0] = {q.alert_sync[1], regulator_output_en, running, q.quarters};
            alwt_pkg::IDX_TIMER_CMD: begin
            end
            default:                   d.rresp = alwt_pkg::RESP_SLVERR;
         endcase
      end

      if (sys_rst) begin
         d = '0;
         d.fsm  = alwt_pkg::ALWT_IDLE;
         d.mask = alwt_pkg::MASK_DEFAULT;                                  // RULE5
         d.ctl  = alwt_pkg::CTL_RESET;
      end
   end

   always_ff @(posedge core_clk) begin
      q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready = ~q.aw_got & ~q.bvalid;
   assign s_axi_wready  = ~q.w_got & ~q.bvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = ~q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   // Open drain: output level is always low, only the enable moves
   assign alert_o  = 1'b0;                                                 // RULE22
   assign alert_oe = (q.latched != 16'h0000);                              // RULE3

   // Control setting is overridden only while the timer holds it off
   assign regulator_output_en = q.ctl[alwt_pkg::CTL_REG_EN] & ~(running & q.reg_off); // RULE19
   assign thermistor_mode     = q.ctl[alwt_pkg::CTL_TMODE];               // RULE8
   assign general_adc_input   = ~q.ctl[alwt_pkg::CTL_TMODE];              // RULE8
   assign pullup_en = q.ctl[alwt_pkg::CTL_TMODE] & (pin_measuring | q.ctl[alwt_pkg::CTL_PULLUP]); // RULE9
   assign osc_run   = (power_mode != alwt_pkg::MODE_DEEP) | q.ctl[alwt_pkg::CTL_OSC_KEEP] | running; // RULE20

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_latch_sets: assert property ((raw & q.mask) != 16'h0000 |=> (q.latched & $past(raw & q.mask)) == $past(raw & q.mask)) // RULE2
      else $error("unmasked event not latched");
   a_clear_exact: assert property (wr_fire && wr_idx == alwt_pkg::IDX_LATCHED
         |=> (q.latched & $past(q.latched & ~wval[15:0])) == $past(q.latched & ~wval[15:0])) // RULE4
      else $error("latched flag cleared without a one written");
   a_alert_pull: assert property ($rose(q.latched != 16'h0000) |-> alert_oe && !alert_o) // RULE3
      else $error("alert not pulled low");
   a_timer_start: assert property (tmr_wr && wval[7:0] != 8'h00 |=> running && q.quarters != 10'h000) // RULE12
      else $error("timer did not start");
   a_abort_quiet: assert property (tmr_wr && wval[7:0] == 8'h00 && running |=> !running ##1 !q.pulse) // RULE18
      else $error("abort left timer running or pulsed");
   a_pulse_single: assert property (q.pulse |-> $past(running) && !running ##1 !q.pulse) // RULE13
      else $error("expiry pulse malformed");
   a_reg_held: assert property (running && q.reg_off |-> !regulator_output_en) // RULE19
      else $error("regulator on while held off");
   a_osc_keep: assert property (running && power_mode == alwt_pkg::MODE_DEEP |-> osc_run) // RULE20
      else $error("oscillator stopped with timer active");
   a_pullup_mode: assert property (!thermistor_mode |-> !pullup_en) // RULE9
      else $error("pull-up on in ADC input mode");
   a_write_resp: assert property (wr_fire |=> s_axi_bvalid && !s_axi_awready) // RULE5
      else $error("write not answered");
   a_flag_hold: assert property (!(wr_fire && wr_idx == alwt_pkg::IDX_LATCHED)
         |=> (q.latched & $past(q.latched)) == $past(q.latched)) // RULE6
      else $error("latched flag dropped without a clear");
   a_mask_gate: assert property ((q.latched & ~$past(q.latched) & ~$past(raw & q.mask)) == 16'h0000) // RULE2
      else $error("flag latched without an unmasked source");
   a_expiry_restore: assert property (q.pulse && !running |-> !q.reg_off) // RULE14
      else $error("regulator still held off after expiry");
   a_abort_restore: assert property (tmr_wr && wval[7:0] == 8'h00 && running |=> !q.reg_off && !q.dly_pend) // RULE18
      else $error("regulator still held off after abort");
   a_wake_restore: assert property (running && q.awk && q.sd && q.latched != 16'h0000 && !tmr_wr
         |=> !q.reg_off) // RULE16
      else $error("latched alarm did not restore regulator");
   a_delay_hold: assert property (running && q.dly_pend |-> regulator_output_en == q.ctl[alwt_pkg::CTL_REG_EN]) // RULE15
      else $error("regulator cut before its delay ran out");

endmodule : alwt_top

// >>> alwt_host_model.sv
// Host side of the alert line: pull-up resistor and interrupt edge counter
`timescale 1ns/1ps
module alwt_host_model (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       alert_o,
   input  wire logic       alert_oe,
   output      logic       alert_wire,
   output      logic [7:0] irq_count
);
   logic alert_d;
   // Nobody drives the line high, the pull-up does
   assign alert_wire = alert_oe ? alert_o : 1'b1;
   always_ff @(posedge core_clk) begin
      alert_d <= sys_rst ? 1'b1 : alert_wire;
      if (sys_rst) irq_count <= 8'h00;
      else if (alert_d && !alert_wire) irq_count <= irq_count + 8'h01;
   end
endmodule : alwt_host_model

// >>> alwt_top_tb.sv
// Self-checking bench of the alarm latch and wake timer
`timescale 1ns/1ps
module alwt_top_tb;
   // Short quarter tick keeps the longest interval, 972 quarters, under eight thousand cycles
   localparam int T = 8;
   logic        core_clk = 1'b0, sys_rst = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, alert_o, alert_oe, alert_i;
   logic        reg_en, pullup_en, tmode, adc_in, osc_run;
   logic [1:0]  bresp, rresp, last_resp, power_mode = 2'h0;
   logic [15:0] event_src = 16'h0000, pin_voltage = 16'h5a3c;
   logic        powerup_flag = 1'b0, pin_measuring = 1'b0;
   logic [7:0]  irq_count;
   int          n_mismatch = 0, total_checks = 0, cyc = 0;
   always #4 core_clk = ~core_clk;
   alwt_top #(.TICK_CYCLES(T)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .event_src(event_src), .powerup_flag(powerup_flag), .pin_voltage(pin_voltage),
      .pin_measuring(pin_measuring), .power_mode(power_mode), .alert_i(alert_i), .alert_o(alert_o),
      .alert_oe(alert_oe), .regulator_output_en(reg_en), .pullup_en(pullup_en), .thermistor_mode(tmode),
      .general_adc_input(adc_in), .osc_run(osc_run));
   alwt_host_model i_host (.core_clk(core_clk), .sys_rst(sys_rst), .alert_o(alert_o), .alert_oe(alert_oe),
      .alert_wire(alert_i), .irq_count(irq_count));
   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // Address and data offered together; each dropped at the edge that takes it
   task automatic wr(input logic [9:0] idx, input logic [15:0] d);
      logic ta, tw, da, dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge core_clk);
      awaddr <= {idx, 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(da && dw)) begin
         @(negedge core_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         da = da | ta;
         dw = dw | tw;
      end
      do @(negedge core_clk); while (bvalid !== 1'b1);
      last_resp = bresp;
      @(posedge core_clk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge core_clk); while (arready !== 1'b1);
      @(posedge core_clk);
      arvalid <= 1'b0;
      do @(negedge core_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      rready <= 1'b0;
   endtask : rd
   task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(idx, d, r);
      chk(d, exp);
      chk({30'h0, r}, {30'h0, alwt_pkg::RESP_OKAY});
   endtask : rdchk
   task automatic wait_alert(output int n);
      n = 0;
      while (alert_oe !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
   endtask : wait_alert
   task automatic drive_ev(input logic [15:0] v);
      @(posedge core_clk);
      event_src <= v;
   endtask : drive_ev
   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rdchk(alwt_pkg::IDX_MASK, 32'h00000000);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000000);
      rdchk(alwt_pkg::IDX_PIN_RESULT, 32'h00005a3c);
      chk(alert_i, 32'h1);
      rdchk(alwt_pkg::IDX_TIMER_STAT, 32'h00001800);
      wr(alwt_pkg::IDX_MASK, 16'h0000);
      chk(last_resp, alwt_pkg::RESP_OKAY);
      wr(10'h011, 16'h0000);
      chk(last_resp, alwt_pkg::RESP_SLVERR);
      rd(10'h011, d, r);
      chk(r, alwt_pkg::RESP_SLVERR);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_events;
      drive_ev(16'h0001);
      rdchk(alwt_pkg::IDX_INSTANT, 32'h00000001);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000000);
      wr(alwt_pkg::IDX_MASK, 16'h8003);
      rdchk(alwt_pkg::IDX_MASK, 32'h00008003);
      drive_ev(16'h0002);
      drive_ev(16'h0000);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000003);
      chk({alert_oe, alert_o, alert_i}, 32'h4);
      chk(irq_count, 32'h1);
      wr(alwt_pkg::IDX_LATCHED, 16'h0002);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000001);
      drive_ev(16'h0001);
      wr(alwt_pkg::IDX_LATCHED, 16'h0001);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000001);
      drive_ev(16'h0000);
      wr(alwt_pkg::IDX_LATCHED, 16'h0001);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000000);
      chk(alert_i, 32'h1);
      @(posedge core_clk) powerup_flag <= 1'b1;
      rdchk(alwt_pkg::IDX_INSTANT, 32'h00008000);
      @(posedge core_clk) powerup_flag <= 1'b0;
      rdchk(alwt_pkg::IDX_INSTANT, 32'h00000000);
      wr(alwt_pkg::IDX_LATCHED, 16'h8000);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000000);
      $display("t_events done");
   endtask : t_events
   task automatic t_pin;
      @(posedge core_clk) pin_measuring <= 1'b1;
      @(negedge core_clk) chk({tmode, adc_in, pullup_en}, 32'h5);
      @(posedge core_clk) pin_measuring <= 1'b0;
      @(negedge core_clk) chk(pullup_en, 32'h0);
      wr(alwt_pkg::IDX_REG_CONTROL, 16'h0007);
      @(negedge core_clk) chk(pullup_en, 32'h1);
      wr(alwt_pkg::IDX_REG_CONTROL, 16'h0003);
      @(negedge core_clk) chk({tmode, adc_in, pullup_en}, 32'h2);
      wr(alwt_pkg::IDX_REG_CONTROL, 16'h0005);
      $display("t_pin done");
   endtask : t_pin
   task automatic t_timer;
      logic [7:0] s [3] = '{8'h01, 8'h10, 8'h11};
      int         n, q;
      wr(alwt_pkg::IDX_MASK, 16'h1001);
      foreach (s[i]) begin
         q = (s[i] <= 8'h10) ? int'(s[i]) : (int'(s[i]) - 12) * 4;
         wr(alwt_pkg::IDX_TIMER_CMD, {8'h00, s[i]});
         wait_alert(n);
         chk(n >= q * T - 3 && n <= q * T + 3, 32'h1);
         rdchk(alwt_pkg::IDX_LATCHED, 32'h00001000);
         wr(alwt_pkg::IDX_LATCHED, 16'h1000);
      end
      wr(alwt_pkg::IDX_MASK, 16'h0001);
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0001);
      repeat (3 * T) @(negedge core_clk);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000000);
      wr(alwt_pkg::IDX_MASK, 16'h1001);
      $display("t_timer done");
   endtask : t_timer
   task automatic t_regulator_output;
      int n;
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0102);
      @(negedge core_clk) chk(reg_en, 32'h0);
      wr(alwt_pkg::IDX_REG_CONTROL, 16'h0005);
      @(negedge core_clk) chk(reg_en, 32'h0);
      wait_alert(n);
      @(negedge core_clk) chk(reg_en, 32'h1);
      wr(alwt_pkg::IDX_LATCHED, 16'h1000);
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0304);
      @(negedge core_clk) chk(reg_en, 32'h1);
      repeat (T + 3) @(negedge core_clk);
      chk(reg_en, 32'h0);
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0000);
      @(negedge core_clk) chk(reg_en, 32'h1);
      repeat (5 * T) @(negedge core_clk);
      rdchk(alwt_pkg::IDX_LATCHED, 32'h00000000);
      // Longest delay: regulator stays on for sixteen quarters, then goes off
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0714);
      repeat (15 * T) @(negedge core_clk);
      chk(reg_en, 32'h1);
      repeat (2 * T) @(negedge core_clk);
      chk(reg_en, 32'h0);
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0000);
      @(negedge core_clk) chk(reg_en, 32'h1);
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0932);
      @(negedge core_clk) chk(reg_en, 32'h0);
      drive_ev(16'h0001);
      drive_ev(16'h0000);
      repeat (3) @(negedge core_clk);
      chk(reg_en, 32'h1);
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0000);
      wr(alwt_pkg::IDX_LATCHED, 16'h0001);
      $display("t_regulator_output done");
   endtask : t_regulator_output
   task automatic t_deep;
      int n;
      @(posedge core_clk) power_mode <= alwt_pkg::MODE_DEEP;
      @(negedge core_clk) chk(osc_run, 32'h0);
      wr(alwt_pkg::IDX_TIMER_CMD, 16'h0001);
      @(negedge core_clk) chk(osc_run, 32'h1);
      wait_alert(n);
      chk(alert_oe, 32'h1);
      repeat (2) @(negedge core_clk);
      chk(osc_run, 32'h0);
      @(posedge core_clk) power_mode <= 2'h0;
      wr(alwt_pkg::IDX_LATCHED, 16'h1000);
      $display("t_deep done");
   endtask : t_deep
   ////////////////////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_events();
      t_pin();
      t_timer();
      t_regulator_output();
      t_deep();
      end_of_test();
   end
endmodule : alwt_top_tb
